// >>> common/sph_consts.vh
// constants for the serial port handshake block
`ifndef SPH_CONSTS_VH
`define SPH_CONSTS_VH
`define SPH_CLK_HZ        100000000
`define SPH_BAUD          9600
`define SPH_BIT_CYCLES    (`SPH_CLK_HZ / `SPH_BAUD)
`define SPH_DATA_BITS     8
`define SPH_FIFO_DEPTH    32
`define SPH_STOP_BITS     2
`define SPH_DC1           8'h11
`define SPH_DC3           8'h13
`define SPH_DC3_LIMIT     10
`define SPH_ALARM_CODE    10'h086
`endif

// >>> rtl/sph_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sph_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    input  wire             flush
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_q;
    reg [AW:0]      rd_q;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;
    // extra pointer bit tells full from empty
    assign empty     = (wr_q == rd_q);
    assign full      = (wr_q[AW-1:0] == rd_q[AW-1:0])
                     && (wr_q[AW] != rd_q[AW]);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_q[AW-1:0]];
    assign push      = in_valid & ~full;
    assign pop       = out_ready & ~empty;
    // storage array, no reset needed
    always @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
    // pointers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// >>> rtl/sph_top.v
// serial port transmitter with send-request / permit / ready handshake
`timescale 1ns/1ps
`include "sph_consts.vh"

// Summary of operation
// R1: send_request goes on at block start, off when the block ends.
// R2: a character starts only while send permit and peer_ready are both on.
// R3: permit dropping stops output within two characters; resumes on return.
// R4: peer_ready dropping mid-transfer aborts and raises alarm 086.
// R5: controller_ready is on whenever the link can operate.
// R6: peer treats tx_data_line valid only while controller_ready is on.
// R7: peer asserts peer_ready only when powered and ready.
// R8: frame is start bit, eight data bits bit 1 first, then stop bits.
// R9: received DC3 halts output within ten characters; DC1 resumes.
// R10: every bit timed by a bit-rate enable of fixed clock cycle count.
module sph_top #(
    parameter BIT_CYCLES = `SPH_BIT_CYCLES,
    parameter DEPTH      = `SPH_FIFO_DEPTH
) (
    input  wire       MCLK,
    input  wire       RESET,
    input  wire [7:0] TX_BYTE,
    input  wire       TX_VALID,
    output wire       TX_READY,
    input  wire       BLOCK_END,
    input  wire       SEND_PERMIT,
    input  wire       PEER_READY,
    input  wire [7:0] RX_BYTE,
    input  wire       RX_STROBE,
    input  wire       ALARM_CLEAR,
    output reg        TX_DATA_LINE,
    output reg        SEND_REQUEST,
    output reg        CONTROLLER_READY,
    output reg        ALARM,
    output reg  [9:0] ALARM_NUMBER,
    output reg        BUSY
);
    // *****************************************************
    // states and declarations
    // *****************************************************
    localparam ST_IDLE  = 4'b0001;
    localparam ST_START = 4'b0010;
    localparam ST_DATA  = 4'b0100;
    localparam ST_STOP  = 4'b1000;
    localparam AW       = $clog2(DEPTH);
    localparam [AW:0] OCC_FULL = DEPTH;
    localparam [AW:0] OCC_ONE  = 1;

    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [31:0] baud_q;
    reg  [2:0]  bit_q;
    reg         stop_q;
    reg  [7:0]  shift_q;
    reg         active_q;
    reg         end_q;
    reg         xoff_q;
    reg         in_ready_q;
    reg  [AW:0] occ_q;
    reg  [AW:0] occ_d;
    wire        push_w;
    wire        tick;
    wire [7:0]  f_data;
    wire        f_valid;
    wire        f_ready;
    wire        f_pop;
    wire        go;
    wire        abort;

    // *****************************************************
    // buffer in the data path
    // *****************************************************
    sph_fifo #(
        .WIDTH (`SPH_DATA_BITS),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .clk       (MCLK),
        .rst       (RESET),
        .in_data   (TX_BYTE),
        .in_valid  (TX_VALID),
        .in_ready  (f_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .flush     (abort)
    );

    // bit-rate enable: one tick per bit period
    assign tick = (baud_q == BIT_CYCLES - 1); // R10
    // new character only with permit, ready and no xoff
    // permit is sampled between characters, so at most the current
    // character plus none more go out: within two characters
    assign go = (state_q == ST_IDLE) && f_valid && SEND_PERMIT
              && PEER_READY && !xoff_q && !ALARM; // R2 R3 R9
    assign f_pop = go;
    assign abort = active_q && !PEER_READY; // R4

    // *****************************************************
    // frame sequencer
    // *****************************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (go) state_d = ST_START;
            end
            ST_START: begin
                if (tick) state_d = ST_DATA;
            end
            ST_DATA: begin
                if (tick && bit_q == 3'd7) state_d = ST_STOP;
            end
            ST_STOP: begin
                if (tick && stop_q) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        if (abort) state_d = ST_IDLE;
    end

    // baud counter restarts at each frame start
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            baud_q <= 32'h0;
        end else if (state_q == ST_IDLE || tick) begin
            baud_q <= 32'h0; // R10
        end else begin
            baud_q <= baud_q + 32'h1;
        end
    end

    // shifter and line driver, lsb (bit 1) first
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state_q      <= ST_IDLE;
            bit_q        <= 3'h0;
            stop_q       <= 1'b0;
            shift_q      <= 8'h00;
            TX_DATA_LINE <= 1'b1;
        end else begin
            state_q <= state_d;
            if (abort) begin
                TX_DATA_LINE <= 1'b1; // idle mark on abort
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        bit_q  <= 3'h0;
                        stop_q <= 1'b0;
                        if (go) begin
                            shift_q      <= f_data;
                            TX_DATA_LINE <= 1'b0; // R8
                        end
                    end
                    ST_START: begin
                        if (tick) begin
                            TX_DATA_LINE <= shift_q[0]; // R8
                            shift_q      <= {1'b0, shift_q[7:1]};
                        end
                    end
                    ST_DATA: begin
                        if (tick) begin
                            bit_q <= bit_q + 3'h1;
                            if (bit_q == 3'd7) begin
                                TX_DATA_LINE <= 1'b1; // R8
                            end else begin
                                TX_DATA_LINE <= shift_q[0];
                                shift_q      <= {1'b0, shift_q[7:1]};
                            end
                        end
                    end
                    ST_STOP: begin
                        if (tick) stop_q <= 1'b1; // two stop bits
                        TX_DATA_LINE <= 1'b1;
                    end
                    default: TX_DATA_LINE <= 1'b1;
                endcase
            end
        end
    end

    // *****************************************************
    // handshake, flow control and alarm
    // *****************************************************
    // block lasts from first character until end marked and all sent
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            active_q     <= 1'b0;
            end_q        <= 1'b0;
            SEND_REQUEST <= 1'b0;
            BUSY         <= 1'b0;
        end else begin
            if (abort) begin
                active_q <= 1'b0;
                end_q    <= 1'b0;
            end else if (go) begin
                active_q <= 1'b1; // R1
            end else if (active_q && end_q && !f_valid
                         && state_q == ST_IDLE) begin
                active_q <= 1'b0; // R1
                end_q    <= 1'b0;
            end
            if (BLOCK_END && (active_q || f_valid) && !abort) end_q <= 1'b1;
            SEND_REQUEST <= (active_q && !abort) || go; // R1
            BUSY         <= (state_q != ST_IDLE) || f_valid;
        end
    end

    // xoff latch from received control codes; checked per character so
    // the halt lands well inside ten characters
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            xoff_q <= 1'b0;
        end else if (RX_STROBE && RX_BYTE == `SPH_DC3) begin
            xoff_q <= 1'b1; // R9
        end else if (RX_STROBE && RX_BYTE == `SPH_DC1) begin
            xoff_q <= 1'b0; // R9
        end
    end

    // alarm is sticky; a new abort wins over a clear in the same cycle
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ALARM        <= 1'b0;
            ALARM_NUMBER <= 10'h000;
        end else if (abort) begin
            ALARM        <= 1'b1; // R4
            ALARM_NUMBER <= `SPH_ALARM_CODE; // R4
        end else if (ALARM_CLEAR) begin
            ALARM        <= 1'b0;
            ALARM_NUMBER <= 10'h000;
        end
    end

    // occupancy mirror of the fifo so that ready can come from a flop;
    // a flush on abort empties it whatever else happens that cycle
    assign push_w = TX_VALID & f_ready;
    always @* begin
        occ_d = occ_q;
        if (abort) begin
            occ_d = {(AW+1){1'b0}};
        end else if (push_w && !f_pop) begin
            occ_d = occ_q + OCC_ONE;
        end else if (!push_w && f_pop) begin
            occ_d = occ_q - OCC_ONE;
        end
    end

    // ready whenever not out of reset trouble and no alarm standing
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            CONTROLLER_READY <= 1'b0;
            in_ready_q       <= 1'b1;
            occ_q            <= {(AW+1){1'b0}};
        end else begin
            CONTROLLER_READY <= !ALARM && !abort; // R5
            in_ready_q       <= (occ_d != OCC_FULL);
            occ_q            <= occ_d;
        end
    end

    // ready is next cycle's not-full taken from the mirror, so it
    // matches the fifo exactly: a byte offered while high is taken unless an abort flushes the fifo that cycle
    assign TX_READY = in_ready_q;
endmodule

// >>> bench/sph_top_sva.sv
// assertion checker bound to the serial port handshake top
`timescale 1ns/1ps
`include "sph_consts.vh"
module sph_top_sva #(
    parameter BIT_CYCLES = 4
) (
    input wire       MCLK,
    input wire       RESET,
    input wire       SEND_PERMIT,
    input wire       PEER_READY,
    input wire       TX_DATA_LINE,
    input wire       SEND_REQUEST,
    input wire       CONTROLLER_READY,
    input wire       ALARM,
    input wire [9:0] ALARM_NUMBER
);
    // ********************
    // helper logic
    // ********************
    reg  [15:0] run_q;
    reg         line_q;
    reg  [3:0]  pcnt_q;
    reg  [31:0] frm_q;
    localparam [31:0] FRAME_LEN = 10 * BIT_CYCLES;
    // a fall counts as a start only outside a frame: data bits that
    // go low inside a character must not be taken for new starts
    wire        start_w = line_q & ~TX_DATA_LINE & (frm_q == 32'h0);

    // length of the current line level; starts seen with permit off
    always @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            run_q  <= 16'h0;
            line_q <= 1'b1;
            pcnt_q <= 4'h0;
            frm_q  <= 32'h0;
        end else begin
            frm_q  <= start_w ? FRAME_LEN - 32'h1
                    : (frm_q != 32'h0) ? frm_q - 32'h1 : 32'h0;
            run_q  <= (TX_DATA_LINE != line_q) ? 16'h1 : run_q + 16'h1;
            line_q <= TX_DATA_LINE;
            pcnt_q <= SEND_PERMIT ? 4'h0 : pcnt_q + {3'h0, start_w};
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    // abort path: alarm code, readiness and timing of the alarm
    alarm_code_a: assert property (
        ALARM |-> ALARM_NUMBER == `SPH_ALARM_CODE)
        else $error("alarm number wrong");
    alarm_abort_a: assert property (
        $fell(PEER_READY) && SEND_REQUEST |-> ##[1:2] ALARM)
        else $error("no alarm after peer drop");
    ready_link_a: assert property (!ALARM [*3] |-> CONTROLLER_READY)
        else $error("controller ready low without alarm");
    alarm_ready_a: assert property (ALARM [*2] |-> !CONTROLLER_READY)
        else $error("controller ready high in alarm");
    // a start may follow the decision by one cycle, so look two back
    start_gate_a: assert property (
        start_w |->
        ($past(SEND_PERMIT) || $past(SEND_PERMIT, 2)) &&
        ($past(PEER_READY) || $past(PEER_READY, 2)))
        else $error("character started without permit");
    // a low run is start plus zero bits, so a whole number of bits
    bit_time_a: assert property (
        $rose(TX_DATA_LINE) && PEER_READY && $past(PEER_READY) &&
        $past(PEER_READY, 2) |-> run_q % BIT_CYCLES == 0)
        else $error("bit length wrong");
    start_req_a: assert property ($fell(TX_DATA_LINE) |-> SEND_REQUEST)
        else $error("character without send request");
    permit_stop_a: assert property (
        !SEND_PERMIT && start_w |-> pcnt_q == 4'h0)
        else $error("too many characters after permit off");

    cover property ($rose(ALARM));
    cover property ($fell(SEND_REQUEST));
    cover property (!SEND_PERMIT && start_w);
endmodule

bind sph_top sph_top_sva #(.BIT_CYCLES(BIT_CYCLES)) u_sva (
    .MCLK             (MCLK),
    .RESET            (RESET),
    .SEND_PERMIT      (SEND_PERMIT),
    .PEER_READY       (PEER_READY),
    .TX_DATA_LINE     (TX_DATA_LINE),
    .SEND_REQUEST     (SEND_REQUEST),
    .CONTROLLER_READY (CONTROLLER_READY),
    .ALARM            (ALARM),
    .ALARM_NUMBER     (ALARM_NUMBER)
);

// >>> bench/sph_peer.sv
// receiving peer model: decodes frames from the serial output
`timescale 1ns/1ps
module sph_peer #(
    parameter BIT_CYCLES = 4
) (
    input wire clk,
    input wire line,
    input wire ctl_ready
);
    // ********************
    // frame receiver
    // ********************
    logic [7:0] got[$];
    logic [7:0] b;

    // sample each bit near its middle; the line means nothing when
    // the controller is not ready, so such frames are skipped
    initial forever begin
        @(posedge clk);
        if (ctl_ready === 1'b1 && line === 1'b0) begin
            repeat (BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk);
                b[i] = line;
            end
            repeat (BIT_CYCLES) @(posedge clk);
            if (line === 1'b1)
                got.push_back(b);
        end
    end
endmodule

// >>> bench/sph_top_tb_top.sv
// self-checking bench for the serial port handshake top
`timescale 1ns/1ps
`include "sph_consts.vh"
module sph_top_tb_top;
    localparam int BC = 4;
    logic        MCLK = 1'b0;
    logic        RESET = 1'b1;
    logic [7:0]  TX_BYTE = 8'h00;
    logic        TX_VALID = 1'b0;
    logic        BLOCK_END = 1'b0;
    logic        SEND_PERMIT = 1'b1;
    logic        PEER_READY = 1'b1;
    logic [7:0]  RX_BYTE = 8'h00;
    logic        RX_STROBE = 1'b0;
    logic        ALARM_CLEAR = 1'b0;
    wire         TX_READY, TX_DATA_LINE, SEND_REQUEST;
    wire         CONTROLLER_READY, ALARM, BUSY;
    wire  [9:0]  ALARM_NUMBER;
    int          err_count = 0;
    int          comparisons = 0;
    int          n;
    // byte sent in the high half, byte the peer should see in the low
    logic [15:0] rows [5] = '{16'h0000, 16'hffff, 16'ha5a5, 16'h0101,
                              16'h8080};

    // ********************
    // harness
    // ********************
    always #5 MCLK = ~MCLK;

    sph_top #(.BIT_CYCLES(BC), .DEPTH(`SPH_FIFO_DEPTH)) u_dut (
        .MCLK(MCLK), .RESET(RESET), .TX_BYTE(TX_BYTE),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .BLOCK_END(BLOCK_END),
        .SEND_PERMIT(SEND_PERMIT), .PEER_READY(PEER_READY),
        .RX_BYTE(RX_BYTE), .RX_STROBE(RX_STROBE),
        .ALARM_CLEAR(ALARM_CLEAR), .TX_DATA_LINE(TX_DATA_LINE),
        .SEND_REQUEST(SEND_REQUEST), .CONTROLLER_READY(CONTROLLER_READY),
        .ALARM(ALARM), .ALARM_NUMBER(ALARM_NUMBER), .BUSY(BUSY));

    sph_peer #(.BIT_CYCLES(BC)) u_peer (.clk(MCLK), .line(TX_DATA_LINE),
        .ctl_ready(CONTROLLER_READY));

    task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // a spent wait counts as a mismatch and ends the run
    task lim(input string nm);
        chk(nm, 10'h1, 10'h0);
        test_done;
    endtask

    // inputs move 1 ns after the edge, away from the sampling point
    task tick(input int k);
        repeat (k) @(posedge MCLK);
        #1;
    endtask

    // valid stays up so bytes go back to back; caller lowers it
    task send(input logic [7:0] b);
        TX_BYTE = b;
        TX_VALID = 1'b1;
        for (n = 0; TX_READY !== 1'b1 && n < 9000; n++)
            tick(1);
        if (n >= 9000)
            lim("tx_ready");
        tick(1);
    endtask

    task rx(input logic [7:0] b);
        RX_BYTE = b;
        RX_STROBE = 1'b1;
        tick(1);
        RX_STROBE = 1'b0;
    endtask

    // closes the block, then waits for the request to drop
    task end_block;
        TX_VALID = 1'b0;
        BLOCK_END = 1'b1;
        tick(1);
        BLOCK_END = 1'b0;
        for (n = 0; SEND_REQUEST !== 1'b0 && n < 9000; n++)
            tick(1);
        if (n >= 9000)
            lim("send_request");
        tick(3 * BC);
    endtask

    // run-time guard
    initial begin
        #900000;
        lim("run time");
    end

    // ********************
    // scenarios
    // ********************
    initial begin
        tick(3);
        RESET = 1'b0;
        chk("line", TX_DATA_LINE, 1);
        chk("request", SEND_REQUEST, 0);
        chk("alarm", ALARM, 0);
        chk("alarm number", ALARM_NUMBER, 0);
        chk("busy", BUSY, 0);
        tick(1);
        chk("ctl ready", CONTROLLER_READY, 1);
        $display("test reset done");
        foreach (rows[i])
            send(rows[i][15:8]);
        chk("request", SEND_REQUEST, 1);
        end_block;
        chk("request", SEND_REQUEST, 0);
        foreach (rows[i])
            chk("rx byte", u_peer.got[i], rows[i][7:0]);
        u_peer.got.delete();
        $display("test rows done");
        // halt by permit, then by the stop code; both must resume
        for (int k = 0; k < 2; k++) begin
            // permit drops just as the first start shows on the line
            repeat (2) send(8'h3c);
            if (k == 0)
                SEND_PERMIT = 1'b0;
            repeat (10) send(8'h3c);
            TX_VALID = 1'b0;
            if (k != 0)
                rx(`SPH_DC3);
            tick(600);
            if (k == 0)
                chk("permit halt", u_peer.got.size() <= 2, 1);
            else
                chk("code halt", u_peer.got.size() <= 10, 1);
            chk("busy", BUSY, 1);
            if (k == 0)
                SEND_PERMIT = 1'b1;
            else
                rx(`SPH_DC1);
            end_block;
            chk("resumed", 10'(u_peer.got.size()), 10'd12);
            u_peer.got.delete();
            $display("test halt %0d done", k);
        end
        // fill until refused while the peer withholds permit
        SEND_PERMIT = 1'b0;
        TX_VALID = 1'b1;
        for (n = 0; TX_READY === 1'b1 && n < 40; n++) begin
            TX_BYTE = n[7:0];
            tick(1);
        end
        TX_VALID = 1'b0;
        chk("fifo depth", 10'(n), 10'(`SPH_FIFO_DEPTH));
        tick(20 * BC);
        chk("line held", TX_DATA_LINE, 1);
        chk("refused", TX_READY, 0);
        SEND_PERMIT = 1'b1;
        tick(4);
        end_block;
        chk("drained", 10'(u_peer.got.size()), 10'(`SPH_FIFO_DEPTH));
        chk("last byte", u_peer.got[31], 10'h1f);
        $display("test fifo done");
        // peer power lost mid block
        repeat (3) send(8'h55);
        TX_VALID = 1'b0;
        tick(3 * BC);
        PEER_READY = 1'b0;
        tick(3);
        chk("alarm", ALARM, 1);
        chk("alarm number", ALARM_NUMBER, `SPH_ALARM_CODE);
        chk("ctl ready", CONTROLLER_READY, 0);
        chk("line", TX_DATA_LINE, 1);
        tick(60 * BC);
        chk("sticky", ALARM, 1);
        PEER_READY = 1'b1;
        ALARM_CLEAR = 1'b1;
        tick(1);
        ALARM_CLEAR = 1'b0;
        tick(3);
        chk("cleared", ALARM, 0);
        chk("alarm number", ALARM_NUMBER, 0);
        chk("ctl ready", CONTROLLER_READY, 1);
        chk("flushed", BUSY, 0);
        $display("test abort done");
        test_done;
    end
endmodule
